// [gyro_register_map_upper.sv]
// Wishbone register bank of the angular-rate sensor, upper map
module gyro_register_map_upper
   import gyro_regs_pkg::*;
#(
   parameter logic [19:0] HR_STEP = 20'(HR_STEP_CYCLES)
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:2] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Lower read-only status, location n in bits 8n+7:8n
   input wire logic [119:0] lower_status_i,
   // Buffer output
   input wire logic [7:0] buffer_data_i,
   output logic buffer_pop_o,
   output logic [1:0] buffer_mode_o,
   output logic [1:0] data_select_o,
   output logic frame_marker_o,
   output logic [6:0] watermark_level_o,
   // Self-test
   output logic self_test_start_o,
   input wire logic self_test_done_i,
   input wire logic self_test_fail_i,
   input wire logic rate_ok_i,
   // Offsets
   output logic [11:0] offset_x_o,
   output logic [11:0] offset_y_o,
   output logic [11:0] offset_z_o,
   output logic [7:0] general_purpose_word_o,
   // Configuration fields
   output logic [5:0] interface_cfg_o,
   output logic [7:0] fast_offset_ctrl_o,
   output logic [7:0] slow_offset_ctrl_o,
   // Nonvolatile memory
   output logic nvm_prog_o,
   output logic nvm_load_o,
   input wire logic nvm_ready_i,
   input wire logic [3:0] nvm_remain_i,
   // High-rate detection
   input wire logic rate_over_y_i,
   input wire logic rate_over_z_i,
   output logic [4:0] rate_alarm_threshold_axis2_o,
   output logic [1:0] rate_alarm_hysteresis_axis2_o,
   output logic [4:0] rate_alarm_threshold_axis3_o,
   output logic [1:0] rate_alarm_hysteresis_axis3_o,
   output logic high_rate_y_o,
   output logic high_rate_z_o,
   // Sequence launches
   output logic soft_reset_o,
   output logic int_clear_o,
   // Interrupt
   output logic irq_o
);
   logic [7:0] regs [REG_COUNT];
   logic [6:0] idx;
   logic in_map;
   logic req;
   logic wr;
   logic rd;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [3:0] irq_event;
   logic [3:0] irq_clear;
   logic st_done_q;
   logic nvm_ready_q;
   logic soft_restore;
   logic wr_soft_reset;
   logic wr_int_ctrl;
   logic wr_self_test;
   logic wr_nvm;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic rd_buf_out;
   logic st_done_rise;
   logic nvm_ready_rise;

   high_rate_if hr_y ();
   high_rate_if hr_z ();

   assign idx = wb_adr_i;
   assign in_map = idx < 7'(REG_COUNT);
   // One request taken per access, on the edge that raises ack
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign rd = req && !wb_we_i;
   assign wbyte = wb_dat_i[7:0];

   // Strobes per location, shared by the launch logic
   assign wr_soft_reset = wr && idx == IDX_SOFT_RESET;
   assign wr_int_ctrl = wr && idx == IDX_INT_CTRL;
   assign wr_self_test = wr && idx == IDX_SELF_TEST;
   assign wr_nvm = wr && idx == IDX_NVM;
   assign wr_irq_status = wr && idx == IDX_IRQ_STATUS;
   assign wr_irq_mask = wr && idx == IDX_IRQ_MASK;
   assign rd_buf_out = rd && idx == IDX_BUF_OUT;

   // Bus answer, one wait state
   // A master that keeps stb up after ack starts a second access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // read-only range never stored
   // Soft restore reuses the reset table one edge after the write
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
         if (rst_i || soft_restore) begin
            regs[i] <= reset_value(7'(i));
         end else if (wr && idx == 7'(i)) begin
            regs[i] <= (wbyte & store_mask(7'(i))) | (regs[i] & ~store_mask(7'(i)));
         end
      end
   end

   // Read path: stored bits, then live fields
   // Locations above the irq pair read zero
   always_comb begin
      rd_byte = 8'h00;
      if (idx <= IDX_RO_LAST) begin
         rd_byte = lower_status_i[8 * idx[3:0] +: 8];
      end else if (in_map) begin
         // trigger bits read back as zero
         rd_byte = regs[idx[5:0]] & store_mask(idx);
      end
      unique case (idx)
         IDX_SELF_TEST: begin
            rd_byte[ST_DONE_BIT] = self_test_done_i;
            rd_byte[ST_FAIL_BIT] = self_test_fail_i;
            rd_byte[ST_RATE_OK_BIT] = rate_ok_i;
         end
         IDX_NVM: begin
            rd_byte[NVM_READY_BIT] = nvm_ready_i;
            rd_byte[7:4] = nvm_remain_i;
         end
         IDX_BUF_OUT: rd_byte = buffer_data_i;
         IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status};
         IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask};
         default: ;
      endcase
   end

   // Read data held in flip-flops; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd) begin
         wb_dat_o <= {24'h00_0000, rd_byte};
      end
   end

   // each read of the output port takes one byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buffer_pop_o <= 1'b0;
      end else begin
         buffer_pop_o <= rd_buf_out;
      end
   end

   // soft reset pulse and restore of locations below 0x40; irq status and mask keep their values
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_reset_o <= 1'b0;
         soft_restore <= 1'b0;
      end else begin
         soft_reset_o <= wr_soft_reset;
         soft_restore <= wr_soft_reset;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_clear_o <= 1'b0;
      end else begin
         int_clear_o <= wr_int_ctrl && wbyte[INT_CLEAR_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         self_test_start_o <= 1'b0;
      end else begin
         self_test_start_o <= wr_self_test && wbyte[ST_TRIG_BIT];
      end
   end

   // program needs the unlock bit already set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nvm_prog_o <= 1'b0;
      end else begin
         nvm_prog_o <= wr_nvm && wbyte[NVM_PROG_BIT] && regs[IDX_NVM[5:0]][NVM_UNLOCK_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nvm_load_o <= 1'b0;
      end else begin
         nvm_load_o <= wr_nvm && wbyte[NVM_LOAD_BIT];
      end
   end

   assign buffer_mode_o = regs[IDX_BUF_CFG[5:0]][7:6];
   assign data_select_o = regs[IDX_BUF_CFG[5:0]][1:0];
   assign frame_marker_o = regs[IDX_BUF_WM[5:0]][7];
   assign watermark_level_o = regs[IDX_BUF_WM[5:0]][6:0];
   // low bits from 0x36 and 0x3A
   assign offset_x_o = {regs[IDX_OFS_HI_X[5:0]], regs[IDX_OFS_LOW[5:0]][7:6], regs[IDX_GP_LOW[5:0]][3:2]};
   assign offset_y_o = {regs[IDX_OFS_HI_Y[5:0]], regs[IDX_OFS_LOW[5:0]][5:3], regs[IDX_GP_LOW[5:0]][1]};
   assign offset_z_o = {regs[IDX_OFS_HI_Z[5:0]], regs[IDX_OFS_LOW[5:0]][2:0], regs[IDX_GP_LOW[5:0]][0]};
   // Upper neighbour of the shared low-bit location
   assign general_purpose_word_o = regs[IDX_GP_LOW[5:0] + 6'h01];
   assign interface_cfg_o = regs[IDX_IF_CFG[5:0]][5:0];
   assign fast_offset_ctrl_o = regs[IDX_FAST_OFS[5:0]];
   assign slow_offset_ctrl_o = regs[IDX_SLOW_OFS[5:0]];
   assign rate_alarm_threshold_axis2_o = regs[IDX_HR_CFG_Y[5:0]][5:1];
   assign rate_alarm_hysteresis_axis2_o = regs[IDX_HR_CFG_Y[5:0]][7:6];
   assign rate_alarm_threshold_axis3_o = regs[IDX_HR_CFG_Z[5:0]][5:1];
   assign rate_alarm_hysteresis_axis3_o = regs[IDX_HR_CFG_Z[5:0]][7:6];

   assign hr_y.enable = regs[IDX_HR_CFG_Y[5:0]][0];
   assign hr_y.over = rate_over_y_i;
   assign hr_y.duration = regs[IDX_HR_DUR_Y[5:0]];
   assign hr_z.enable = regs[IDX_HR_CFG_Z[5:0]][0];
   assign hr_z.over = rate_over_z_i;
   assign hr_z.duration = regs[IDX_HR_DUR_Z[5:0]];
   assign high_rate_y_o = hr_y.active;
   assign high_rate_z_o = hr_z.active;

   // delay timer per axis
   // Both axes share one step length, so one parameter
   high_rate_timer #(
      .STEP_CYCLES(HR_STEP)
   ) u_timer_y (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .hr(hr_y.timer)
   );

   high_rate_timer #(
      .STEP_CYCLES(HR_STEP)
   ) u_timer_z (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .hr(hr_z.timer)
   );

   // Edge history follows the pin even in reset, so a level
   // that is already high gives no event when reset ends
   always_ff @(posedge clk_i) begin
      st_done_q <= self_test_done_i;
   end

   always_ff @(posedge clk_i) begin
      nvm_ready_q <= nvm_ready_i;
   end

   // Rising edges of the level inputs count as events
   assign st_done_rise = self_test_done_i && !st_done_q;
   assign nvm_ready_rise = nvm_ready_i && !nvm_ready_q;

   always_comb begin
      irq_event = 4'h0;
      irq_event[IRQ_HR_Y] = hr_y.fire;
      irq_event[IRQ_HR_Z] = hr_z.fire;
      irq_event[IRQ_ST_DONE] = st_done_rise;
      irq_event[IRQ_NVM_READY] = nvm_ready_rise;
   end

   assign irq_clear = wr_irq_status ? wbyte[3:0] : 4'h0;

   // Sticky status, a new event wins over a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= IRQ_RESET;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_event;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= IRQ_RESET;
      end else if (wr_irq_mask) begin
         irq_mask <= wbyte[3:0];
      end
   end

   // Level output, high until software clears or masks the cause
   assign irq_o = |(irq_status & irq_mask);
endmodule

// [gyro_register_map_upper_assertions.sv]
// Port checks of the upper gyro register bank
module gyro_register_map_upper_assertions
   import gyro_regs_pkg::*;
(
   // Watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:2] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [119:0] lower_status_i,
   input wire logic [7:0] buffer_data_i,
   input wire logic buffer_pop_o,
   input wire logic self_test_start_o,
   input wire logic nvm_load_o,
   input wire logic soft_reset_o,
   input wire logic int_clear_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic take;
   logic rd_ack;
   logic wr_take;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rd_ack = wb_ack_o && !wb_we_i;
   assign wr_take = take && wb_we_i && wb_sel_i[0];
   a_ack_single_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one pulse");
   a_ack_has_request: assert property (wb_ack_o |-> $past(wb_stb_i))
      else $error("ack without request");
   a_read_upper_zero: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
      else $error("read bits above byte set");
   a_pop_on_read: assert property (buffer_pop_o == (rd_ack && wb_adr_i == IDX_BUF_OUT))
      else $error("pop not tied to buffer read");
   a_buffer_byte: assert property (rd_ack && wb_adr_i == IDX_BUF_OUT
      |-> wb_dat_o[7:0] == $past(buffer_data_i)) else $error("buffer byte wrong");
   a_lower_status_read: assert property (rd_ack && wb_adr_i <= IDX_RO_LAST
      |-> wb_dat_o[7:0] == 8'($past(lower_status_i) >> {wb_adr_i, 3'h0})) else $error("status byte wrong");
   a_trigger_reads_zero: assert property (rd_ack && wb_adr_i == IDX_SOFT_RESET |-> wb_dat_o == 32'h0)
      else $error("reset location not zero");
   a_soft_reset_launch: assert property (wr_take && wb_adr_i == IDX_SOFT_RESET |-> ##[1:2] soft_reset_o)
      else $error("soft reset not launched");
   a_int_clear_launch: assert property (wr_take && wb_adr_i == IDX_INT_CTRL && wb_dat_i[INT_CLEAR_BIT]
      |-> ##[1:2] int_clear_o) else $error("interrupt clear not launched");
   a_self_test_launch: assert property (wr_take && wb_adr_i == IDX_SELF_TEST && wb_dat_i[ST_TRIG_BIT]
      |-> ##[1:2] self_test_start_o) else $error("self-test not launched");
   a_nvm_load_launch: assert property (wr_take && wb_adr_i == IDX_NVM && wb_dat_i[NVM_LOAD_BIT]
      |-> ##[1:2] nvm_load_o) else $error("nvm load not launched");
   c_buffer_read: cover property (rd_ack && wb_adr_i == IDX_BUF_OUT);
   c_soft_reset: cover property (soft_reset_o);
   c_irq_rise: cover property ($rose(irq_o));
endmodule

// [gyro_regs_pkg.sv]
// Constants, layouts and reset values of the gyro register bank
package gyro_regs_pkg;
   localparam int unsigned REG_COUNT = 64;
   localparam logic [6:0] IDX_RO_LAST = 7'h0E;
   localparam logic [6:0] IDX_SOFT_RESET = 7'h14;
   localparam logic [6:0] IDX_INT_CTRL = 7'h21;
   localparam logic [6:0] IDX_HR_CFG_Y = 7'h24;
   localparam logic [6:0] IDX_HR_DUR_Y = 7'h25;
   localparam logic [6:0] IDX_HR_CFG_Z = 7'h26;
   localparam logic [6:0] IDX_HR_DUR_Z = 7'h27;
   localparam logic [6:0] IDX_CFG_A = 7'h28;
   localparam logic [6:0] IDX_CFG_B = 7'h29;
   localparam logic [6:0] IDX_CFG_C = 7'h2A;
   localparam logic [6:0] IDX_CFG_D = 7'h30;
   localparam logic [6:0] IDX_SLOW_OFS = 7'h31;
   localparam logic [6:0] IDX_FAST_OFS = 7'h32;
   localparam logic [6:0] IDX_NVM = 7'h33;
   localparam logic [6:0] IDX_IF_CFG = 7'h34;
   localparam logic [6:0] IDX_OFS_LOW = 7'h36;
   localparam logic [6:0] IDX_OFS_HI_X = 7'h37;
   localparam logic [6:0] IDX_OFS_HI_Y = 7'h38;
   localparam logic [6:0] IDX_OFS_HI_Z = 7'h39;
   localparam logic [6:0] IDX_GP_LOW = 7'h3A;
   localparam logic [6:0] IDX_SELF_TEST = 7'h3C;
   localparam logic [6:0] IDX_BUF_WM = 7'h3D;
   localparam logic [6:0] IDX_BUF_CFG = 7'h3E;
   localparam logic [6:0] IDX_BUF_OUT = 7'h3F;
   localparam logic [6:0] IDX_IRQ_STATUS = 7'h40;
   localparam logic [6:0] IDX_IRQ_MASK = 7'h41;
   // Field positions
   localparam int unsigned INT_CLEAR_BIT = 7;
   localparam int unsigned ST_TRIG_BIT = 0;
   localparam int unsigned ST_DONE_BIT = 1;
   localparam int unsigned ST_FAIL_BIT = 2;
   localparam int unsigned ST_RATE_OK_BIT = 4;
   localparam int unsigned NVM_UNLOCK_BIT = 0;
   localparam int unsigned NVM_PROG_BIT = 1;
   localparam int unsigned NVM_READY_BIT = 2;
   localparam int unsigned NVM_LOAD_BIT = 3;
   localparam int unsigned IRQ_HR_Y = 0;
   localparam int unsigned IRQ_HR_Z = 1;
   localparam int unsigned IRQ_ST_DONE = 2;
   localparam int unsigned IRQ_NVM_READY = 3;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   // Reset values
   localparam logic [7:0] RST_HR_CFG = 8'h02;
   localparam logic [7:0] RST_HR_DUR = 8'h19;
   localparam logic [7:0] RST_CFG_A = 8'h24;
   localparam logic [7:0] RST_CFG_B = 8'h19;
   localparam logic [7:0] RST_CFG_CD = 8'hE8;
   localparam logic [7:0] RST_SLOW_OFS = 8'h60;
   localparam logic [7:0] RST_FAST_OFS = 8'hC0;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Writable, stored bit masks
   localparam logic [7:0] MASK_ALL = 8'hFF;
   localparam logic [7:0] MASK_NONE = 8'h00;
   localparam logic [7:0] MASK_INT_CTRL = 8'h7F;
   localparam logic [7:0] MASK_NVM = 8'h01;
   localparam logic [7:0] MASK_IF_CFG = 8'h3F;
   localparam logic [7:0] MASK_BUF_CFG = 8'hC3;
   // High-rate delay step: 2.5 ms
   localparam int unsigned HR_STEP_NS = 2500000;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned HR_STEP_CYCLES = HR_STEP_NS / CLK_PERIOD_NS;

   function automatic logic [7:0] reset_value(input logic [6:0] idx);
      unique case (idx)
         IDX_HR_CFG_Y, IDX_HR_CFG_Z: reset_value = RST_HR_CFG;
         IDX_HR_DUR_Y, IDX_HR_DUR_Z: reset_value = RST_HR_DUR;
         IDX_CFG_A: reset_value = RST_CFG_A;
         IDX_CFG_B: reset_value = RST_CFG_B;
         IDX_CFG_C, IDX_CFG_D: reset_value = RST_CFG_CD;
         IDX_SLOW_OFS: reset_value = RST_SLOW_OFS;
         IDX_FAST_OFS: reset_value = RST_FAST_OFS;
         default: reset_value = RST_ZERO;
      endcase
   endfunction

   function automatic logic [7:0] store_mask(input logic [6:0] idx);
      if (idx <= IDX_RO_LAST || idx >= IDX_BUF_OUT) begin
         store_mask = MASK_NONE;
      end else begin
         unique case (idx)
            IDX_SOFT_RESET, IDX_SELF_TEST: store_mask = MASK_NONE;
            IDX_INT_CTRL: store_mask = MASK_INT_CTRL;
            IDX_NVM: store_mask = MASK_NVM;
            IDX_IF_CFG: store_mask = MASK_IF_CFG;
            IDX_BUF_CFG: store_mask = MASK_BUF_CFG;
            default: store_mask = MASK_ALL;
         endcase
      end
   endfunction
endpackage

// [high_rate_if.sv]
// Link between the register bank and one high-rate delay timer
interface high_rate_if;
   logic enable;
   logic over;
   logic [7:0] duration;
   logic fire;
   logic active;
   modport bank (output enable, output over, output duration, input fire, input active);
   modport timer (input enable, input over, input duration, output fire, output active);
endinterface

// [high_rate_timer.sv]
// High-rate event delay: fires after (duration + 1) steps of over-threshold
module high_rate_timer
   import gyro_regs_pkg::*;
#(
   parameter logic [19:0] STEP_CYCLES = 20'(HR_STEP_CYCLES)
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bank side
   high_rate_if.timer hr
);
   logic [19:0] prescale;
   logic [8:0] steps;
   logic alarm;
   logic armed;

   assign armed = hr.enable && hr.over;
   assign hr.active = alarm;

   always_ff @(posedge clk_i) begin
      if (rst_i || !armed || alarm) begin
         prescale <= '0;
         steps <= '0;
      end else if (prescale == STEP_CYCLES - 20'h00001) begin
         prescale <= '0;
         steps <= steps + 9'h001;
      end else begin
         prescale <= prescale + 20'h00001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !armed) begin
         alarm <= 1'b0;
         hr.fire <= 1'b0;
      end else begin
         hr.fire <= !alarm && steps == {1'b0, hr.duration} + 9'h001;
         if (steps == {1'b0, hr.duration} + 9'h001) begin
            alarm <= 1'b1;
         end
      end
   end
endmodule

// [sensor_core_model.sv]
// Sensor datapath model behind the register bank pins
module sensor_core_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bank controls
   input wire logic pop_i,
   input wire logic st_start_i,
   input wire logic nvm_prog_i,
   // Bank data
   output logic [7:0] byte_o,
   output logic [119:0] status_o,
   output logic st_done_o,
   output logic [3:0] remain_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] st_cnt;
   always_comb begin
      for (int n = 0; n < 15; n++) begin
         status_o[8 * n +: 8] = 8'hA0 + 8'(n);
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         byte_o <= 8'h00;
      end else if (pop_i) begin
         byte_o <= byte_o + 8'h01;
      end
   end
   // slow answer, done a few cycles later
   always_ff @(posedge clk_i) begin
      if (rst_i || st_start_i) begin
         st_cnt <= rst_i ? 3'h0 : 3'h7;
         st_done_o <= 1'h0;
      end else if (st_cnt != 3'h0) begin
         st_cnt <= st_cnt - 3'h1;
         st_done_o <= (st_cnt == 3'h1);
      end
   end
   // each program run uses up one write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         remain_o <= 4'h5;
      end else if (nvm_prog_i) begin
         remain_o <= remain_o - 4'h1;
      end
   end
endmodule

// [tb_gyro_register_map_upper.sv]
// Self-checking bench of the upper gyro register bank
`define CHECK(act, exp) begin num_checks++; if ((act) !== (exp)) begin error_cnt++; \
   $display("unexpected at %0t: got %h, expected %h", $time, act, exp); end end
module tb_gyro_register_map_upper
   import gyro_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STEP = 4;
   logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, pop, prog, st_start, st_done, irq;
   logic over_y = 1'h0, over_z = 1'h0, st_fail = 1'h0, rate_ok = 1'h1, nvm_rdy = 1'h1, hr_y, hr_z;
   logic [6:0] adr = 7'h00;
   logic [3:0] sel = 4'h0;
   logic [3:0] remain;
   logic [31:0] wdat = 32'h0, rdat, e;
   logic [7:0] buf_byte, r;
   logic [119:0] status;
   logic [11:0] ofs_x, ofs_y, ofs_z;
   logic [7:0] gp_w, fast_o, slow_o;
   logic [6:0] wm_lvl;
   logic [5:0] if_cfg;
   logic [4:0] th_y, th_z;
   logic [1:0] mode, dsel, hy_y, hy_z;
   logic marker;
   logic [7:0] exp_q[$];
   logic [14:0] rst_tab [15] = '{15'h2402, 15'h2519, 15'h2602, 15'h2719, 15'h2824, 15'h2919, 15'h2AE8,
      15'h30E8, 15'h3160, 15'h32C0, 15'h3400, 15'h3D00, 15'h3E00, 15'h3F00, 15'h5000};
   logic [14:0] rw_tab [13] = '{15'h0FFF, 15'h217F, 15'h24FF, 15'h27FF, 15'h31FF, 15'h32FF, 15'h343F,
      15'h36FF, 15'h37FF, 15'h39FF, 15'h3BFF, 15'h3DFF, 15'h3EC3};
   logic [6:0] ro_tab [3] = '{7'h00, 7'h07, 7'h0E};
   int error_cnt = 0, num_checks = 0, seed = 74, n, ty, tz;
   gyro_register_map_upper #(.HR_STEP(20'(STEP))) i_gyro_register_map_upper (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .lower_status_i(status),
      .buffer_data_i(buf_byte), .buffer_pop_o(pop), .buffer_mode_o(mode), .data_select_o(dsel),
      .frame_marker_o(marker), .watermark_level_o(wm_lvl), .self_test_start_o(st_start), .self_test_done_i(st_done),
      .self_test_fail_i(st_fail), .rate_ok_i(rate_ok), .offset_x_o(ofs_x), .offset_y_o(ofs_y), .offset_z_o(ofs_z),
      .general_purpose_word_o(gp_w), .interface_cfg_o(if_cfg), .fast_offset_ctrl_o(fast_o),
      .slow_offset_ctrl_o(slow_o), .nvm_prog_o(prog), .nvm_load_o(), .nvm_ready_i(nvm_rdy), .nvm_remain_i(remain),
      .rate_over_y_i(over_y), .rate_over_z_i(over_z), .rate_alarm_threshold_axis2_o(th_y),
      .rate_alarm_hysteresis_axis2_o(hy_y), .rate_alarm_threshold_axis3_o(th_z), .rate_alarm_hysteresis_axis3_o(hy_z),
      .high_rate_y_o(hr_y), .high_rate_z_o(hr_z), .soft_reset_o(), .int_clear_o(), .irq_o(irq));
   sensor_core_model i_sensor_core_model (.clk_i(clk), .rst_i(rst), .pop_i(pop), .st_start_i(st_start),
      .nvm_prog_i(prog), .byte_o(buf_byte), .status_o(status), .st_done_o(st_done), .remain_o(remain));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [6:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'h1 && k < 20);
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      if (ack !== 1'h1) begin
         error_cnt++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      wb(1'h1, a, d);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      wb(1'h0, a, 8'h00);
   endtask
   // Oldest noted value against every read answer
   always @(posedge clk) begin
      if (ack === 1'h1 && we === 1'h0) begin
         e = {24'h0, exp_q.pop_front()};
         `CHECK(rdat, e)
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      for (int i = 0; i < 15; i++) rd(rst_tab[i][14:8], rst_tab[i][7:0]);
      // reserved positions masked off in expectations
      for (int i = 0; i < 13; i++) begin
         r = 8'($random(seed));
         wr(rw_tab[i][14:8], r);
         rd(rw_tab[i][14:8], r & rw_tab[i][7:0]);
      end
      foreach (ro_tab[i]) begin
         wr(ro_tab[i], 8'h5C);
         rd(ro_tab[i], 8'hA0 + 8'(ro_tab[i]));
      end
      wr(IDX_BUF_OUT, 8'hFF);
      for (int i = 1; i < 4; i++) rd(IDX_BUF_OUT, 8'(i));
      wr(IDX_IRQ_MASK, 8'h04);
      wr(IDX_SELF_TEST, 8'h01);
      for (n = 0; n < 50 && irq !== 1'h1; n++) @(posedge clk);
      `CHECK(irq, 1'h1)
      rd(IDX_SELF_TEST, 8'h12);
      st_fail <= 1'h1;
      rd(IDX_SELF_TEST, 8'h16);
      wr(IDX_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clk);
      `CHECK(irq, 1'h0)
      rd(IDX_IRQ_STATUS, 8'h04);
      wr(IDX_IRQ_STATUS, 8'h04);
      wr(IDX_IRQ_MASK, 8'h04);
      repeat (2) @(posedge clk);
      `CHECK(irq, 1'h0)
      wr(IDX_NVM, 8'h01);
      rd(IDX_NVM, 8'h55);
      wr(IDX_NVM, 8'h0A);
      rd(IDX_NVM, 8'h44);
      nvm_rdy <= 1'h0;
      repeat (2) @(posedge clk);
      nvm_rdy <= 1'h1;
      rd(IDX_IRQ_STATUS, 8'h08);
      wr(IDX_SLOW_OFS, 8'h1F);
      wr(IDX_INT_CTRL, 8'h80);
      rd(IDX_INT_CTRL, 8'h00);
      wr(IDX_SOFT_RESET, 8'hB6);
      rd(IDX_SOFT_RESET, 8'h00);
      rd(IDX_SLOW_OFS, 8'h60);
      `CHECK({fast_o, slow_o}, 16'hC060)
      wr(IDX_OFS_LOW, 8'hC9);
      wr(IDX_OFS_HI_X, 8'hA5);
      wr(IDX_GP_LOW, 8'h0D);
      wr(IDX_GP_LOW + 7'h01, 8'h7E);
      `CHECK({ofs_x, ofs_y, ofs_z}, 36'hA5F002003)
      `CHECK(gp_w, 8'h7E)
      wr(IDX_BUF_CFG, 8'hFF);
      wr(IDX_BUF_WM, 8'hB3);
      wr(IDX_IF_CFG, 8'hFF);
      `CHECK({mode, dsel, marker, wm_lvl, if_cfg}, {2'h3, 2'h3, 1'h1, 7'h33, 6'h3F})
      wr(IDX_HR_DUR_Y, 8'h02);
      wr(IDX_HR_DUR_Z, 8'h05);
      wr(IDX_HR_CFG_Y, 8'h03);
      wr(IDX_HR_CFG_Z, 8'hC3);
      `CHECK({th_y, hy_y, th_z, hy_z}, {5'h01, 2'h0, 5'h01, 2'h3})
      over_y <= 1'h1;
      over_z <= 1'h1;
      ty = 0;
      tz = 0;
      for (n = 1; n < 60 && tz == 0; n++) begin
         @(negedge clk);
         if (hr_y === 1'h1 && ty == 0) ty = n;
         if (hr_z === 1'h1 && tz == 0) tz = n;
      end
      `CHECK(ty >= 3 * STEP && ty <= 3 * STEP + 3, 1'h1)
      `CHECK(tz >= 6 * STEP && tz <= 6 * STEP + 3, 1'h1)
      stop_test();
   end
endmodule
bind gyro_register_map_upper gyro_register_map_upper_assertions i_gyro_register_map_upper_assertions (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .lower_status_i, .buffer_data_i, .buffer_pop_o, .self_test_start_o, .nvm_load_o, .soft_reset_o, .int_clear_o,
   .irq_o);
